/* keyscan_pkg.sv */
package keyscan_pkg;

  // Register offsets.
  localparam logic [7:0] REG_EVENT_QUEUE = 8'h00;
  localparam logic [7:0] REG_SCAN_CONFIG = 8'h01;
  localparam logic [7:0] REG_DEBOUNCE = 8'h02;
  localparam logic [7:0] REG_IRQ_TRIGGER = 8'h03;
  localparam logic [7:0] REG_REPEAT = 8'h05;
  localparam logic [7:0] REG_IDLE_SLEEP = 8'h06;
  localparam logic [7:0] REG_MATRIX_DIM = 8'h30;

  // Reset values.
  localparam logic [7:0] CONFIG_RESET = 8'h0B;
  localparam logic [7:0] DEBOUNCE_RESET = 8'hFF;
  localparam logic [7:0] IRQ_RESET = 8'h00;
  localparam logic [7:0] REPEAT_RESET = 8'h00;
  localparam logic [7:0] SLEEP_RESET = 8'h07;
  localparam logic [7:0] DIM_RESET = 8'hFF;

  // Field positions.
  localparam int CFG_RUN_BIT = 7;
  localparam int CFG_EMPTY_CLEAR_BIT = 5;
  localparam int CFG_RELEASE_BIT = 3;
  localparam int CFG_AUTOWAKE_BIT = 1;
  localparam int REPEAT_EN_BIT = 7;

  // Queue codes.
  localparam logic [7:0] EMPTY_BYTE = 8'h3F;
  localparam logic [7:0] OVERFLOW_BYTE = 8'h7F;
  localparam logic [6:0] REPEAT_CODE = 7'h7E;
  localparam int FIFO_DEPTH = 16;

  // Timing.
  localparam int OSC_HZ = 128000;
  localparam int TICK_HZ = OSC_HZ / 2;
  localparam int DEB_STEP_MS = 2;
  localparam int STEP_TICKS = DEB_STEP_MS * TICK_HZ / 1000;
  localparam int WARMUP_MS = 2;
  localparam int WARMUP_STEPS = WARMUP_MS / DEB_STEP_MS;
  localparam int SLEEP_UNIT_MS = 256;
  localparam int SLEEP_UNIT_STEPS = SLEEP_UNIT_MS / DEB_STEP_MS;
  localparam int REPEAT_DELAY_UNIT = 8;
  localparam int REPEAT_RATE_UNIT = 4;
  localparam int LEVEL_UNIT = 2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } host_access_type;

  typedef enum {PWR_SLEEP, PWR_WARMUP, PWR_RUN} power_state_type;

  typedef enum {
    BUS_IDLE, BUS_ADDR, BUS_ACK, BUS_WDATA, BUS_RDATA, BUS_RACK
  } bus_state_type;

endpackage

/* keyscan_tick_source.sv */
`timescale 1ns/100ps
module keyscan_tick_source (
  // Clocks and reset
  input wire logic clk,
  input wire logic osc_clk,
  input wire logic rst_n,
  // Tick in the system domain
  output logic tick
);

  logic osc_half;
  logic [1:0] half_sync;
  logic half_prev;

  // Halving the oscillator gives the slow tick as a square wave.
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_half <= 1'b0;
    end else begin
      osc_half <= ~osc_half;
    end
  end

  // The square wave is a level, so two flops carry it across safely.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_sync <= 2'b00;
      half_prev <= 1'b0;
      tick <= 1'b0;
    end else begin
      half_sync <= {half_sync[0], osc_half};
      half_prev <= half_sync[1];
      tick <= half_sync[1] & ~half_prev;
    end
  end

endmodule

/* keyscan_host_port.sv */
`timescale 1ns/100ps
module keyscan_host_port #(
  parameter logic [6:0] DEVICE_ADDRESS = 7'h38
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Register access
  output keyscan_pkg::host_access_type access,
  input wire logic [7:0] read_data
);

  keyscan_pkg::bus_state_type state;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_prev;
  logic sda_prev;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic reading;
  logic first_byte;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise = scl_sync[1] & ~scl_prev;
  assign scl_fall = ~scl_sync[1] & scl_prev;
  assign start_seen = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  assign stop_seen = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  // Open drain: the pin is only ever pulled low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= keyscan_pkg::BUS_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      reading <= 1'b0;
      first_byte <= 1'b0;
      sda_oe <= 1'b0;
      access <= '0;
    end else begin
      access.wr <= 1'b0;
      access.rd <= 1'b0;
      if (start_seen) begin
        state <= keyscan_pkg::BUS_ADDR;
        bit_cnt <= 4'h0;
        first_byte <= 1'b1;
        sda_oe <= 1'b0;
      end else if (stop_seen) begin
        state <= keyscan_pkg::BUS_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          keyscan_pkg::BUS_IDLE: begin
          end
          keyscan_pkg::BUS_ADDR, keyscan_pkg::BUS_WDATA: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_sync[1]};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (state == keyscan_pkg::BUS_ADDR) begin
                reading <= shift[0];
                if (shift[7:1] == DEVICE_ADDRESS) begin
                  sda_oe <= 1'b1;
                  state <= keyscan_pkg::BUS_ACK;
                end else begin
                  state <= keyscan_pkg::BUS_IDLE;
                end
              end else begin
                if (first_byte) begin
                  access.addr <= shift;
                end else begin
                  access.wr <= 1'b1;
                  access.data <= shift;
                end
                first_byte <= 1'b0;
                sda_oe <= 1'b1;
                state <= keyscan_pkg::BUS_ACK;
              end
            end
          end
          keyscan_pkg::BUS_ACK, keyscan_pkg::BUS_RACK: begin
            if (scl_rise && state == keyscan_pkg::BUS_RACK
                && sda_sync[1]) begin
              state <= keyscan_pkg::BUS_IDLE;
            end else if (scl_fall) begin
              if (reading) begin
                shift <= {read_data[6:0], 1'b0};
                sda_oe <= ~read_data[7];
                access.rd <= 1'b1;
                state <= keyscan_pkg::BUS_RDATA;
              end else begin
                sda_oe <= 1'b0;
                state <= keyscan_pkg::BUS_WDATA;
              end
            end
          end
          keyscan_pkg::BUS_RDATA: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
                state <= keyscan_pkg::BUS_RACK;
              end else begin
                sda_oe <= ~shift[7];
                shift <= {shift[6:0], 1'b0};
              end
            end
          end
        endcase
      end
    end
  end

endmodule

/* keyscan_event_fifo_controller.sv */
`timescale 1ns/100ps
// What this block does
// RULE1: Debounce and autosleep timing run from a 64kHz tick halved from 128kHz.
// RULE2: Event byte bits 5:0 hold key index, row plus eight times column.
// RULE3: Bit 7 flags more queued data; host rereads after index 62 or 63.
// RULE4: Bit 6 marks press versus release, meaningless for index 62 and 63.
// RULE5: Reading the queue clears the interrupt when config bit 5 selects it.
// RULE6: Config bit 7 picks sleep or run; autosleep and autowake update it.
// RULE7: Debounce register: press time bits 3:0, release bits 7:4, 2ms steps.
// RULE8: An all-zero interrupt register never asserts the interrupt output.
// RULE9: Interrupt bits 4:0 assert 1 to 31 debounce cycles after an event.
// RULE10: Bits 7:5 assert at 2 to 14 queued events; first condition wins.
// RULE11: Autorepeat queues code 0x7E instead of the held key's index.
// RULE12: Repeat bit 7 enables; bits 3:0 give delay of 8 to 128 cycles.
// RULE13: Repeat bits 6:4 give interval of 4 to 32 debounce cycles.
// RULE14: One repeat code per interval, repeating until a new key event.
// RULE15: After a release with keys still held, restart from initial delay.
// RULE16: Autosleep enters sleep after the idle time, keeping queued events.
// RULE17: Size register gives rows in bits 7:4, columns 3:0; zero means none.
// RULE18: Host write of bit 7 or a keypress wakes; bit 7 reads status.
// RULE19: Autowake powers scanning for 2ms, then debounces the waking key.
// RULE20: Config bit 1 enables autowake; zero keeps the device asleep.
// RULE21: Sixteen-entry queue; overflow reads 0x7F first, then stored events.
// RULE22: Without release detection overflow flags at full; 18th release clears.
// RULE23: One queue read returns the next event together with status bits.
// RULE24: Queue clears only on a host transition from sleep to run.
// RULE25: After reset the device is in sleep mode.
// RULE26: Keys outside the configured span are not scanned and make no events.
module keyscan_event_fifo_controller #(
  parameter logic [6:0] DEVICE_ADDRESS = 7'h38
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Internal oscillator
  input wire logic osc_clk,
  // Two-wire host bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Key switches, one bit per key index, high when closed
  input wire logic [63:0] switch_closed,
  // Host interrupt and scan supply
  output logic key_irq_n,
  output logic scan_power_on
);

  function automatic logic in_span(input int unsigned idx,
                                   input logic [7:0] dim);
    logic [5:0] k;
    k = 6'(idx);
    return ({1'b0, k[2:0]} < dim[7:4]) && ({1'b0, k[5:3]} < dim[3:0]);
  endfunction

  keyscan_pkg::host_access_type access;
  keyscan_pkg::power_state_type pstate;
  logic tick;
  logic [7:0] read_data;
  logic [6:0] cfg;
  logic [7:0] debounce;
  logic [7:0] irq_cfg;
  logic [7:0] repeat_cfg;
  logic [7:0] sleep_cfg;
  logic [7:0] dims;
  logic [63:0] sw_meta;
  logic [63:0] sw_sync;
  logic [63:0] deb;
  logic [63:0] rep;
  logic [63:0] span_mask;
  logic [7:0] step_cnt;
  logic step;
  logic [3:0] cyc_cnt;
  logic cycle;
  logic running;
  logic host_wake;
  logic pick_valid;
  logic [5:0] pick_idx;
  logic ev_press;
  logic rel_en;
  logic key_push;
  logic rpt_fire;
  logic push;
  logic [6:0] push_byte;
  logic [7:0] rpt_cnt;
  logic [7:0] next_delay;
  logic [7:0] next_rate;
  logic [6:0] fifo_mem [keyscan_pkg::FIFO_DEPTH];
  logic [3:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic [4:0] count;
  logic full;
  logic ovf;
  logic extra_full;
  logic queue_read;
  logic pop;
  logic push_ok;
  logic [4:0] tcnt;
  logic t_armed;
  logic t_fire;
  logic lvl_hit;
  logic irq;
  logic [9:0] idle_cnt;
  logic [9:0] idle_limit;
  logic [1:0] warm_cnt;

  keyscan_tick_source tick_source (
    .clk(clk),
    .osc_clk(osc_clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  keyscan_host_port #(.DEVICE_ADDRESS(DEVICE_ADDRESS)) host_port (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .access(access),
    .read_data(read_data)
  );

  assign running = pstate == keyscan_pkg::PWR_RUN;
  assign rel_en = cfg[keyscan_pkg::CFG_RELEASE_BIT];
  assign full = count == 5'(keyscan_pkg::FIFO_DEPTH);
  assign host_wake = access.wr && access.addr == keyscan_pkg::REG_SCAN_CONFIG
                     && access.data[keyscan_pkg::CFG_RUN_BIT];
  assign queue_read = access.rd
                      && access.addr == keyscan_pkg::REG_EVENT_QUEUE;
  assign pop = queue_read && !ovf && count != 5'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_meta <= 64'h0;
      sw_sync <= 64'h0;
    end else begin
      sw_meta <= switch_closed;
      sw_sync <= sw_meta;
    end
  end

  // A 2ms step from the slow tick, and a debounce cycle of press length.
  assign step = tick && step_cnt == 8'(keyscan_pkg::STEP_TICKS - 1); // RULE1
  assign cycle = step && cyc_cnt == debounce[3:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt <= 8'h00;
      cyc_cnt <= 4'h0;
    end else begin
      if (step || pstate == keyscan_pkg::PWR_SLEEP) begin
        step_cnt <= 8'h00;
      end else if (tick) begin
        step_cnt <= step_cnt + 8'h01;
      end
      if (cycle) begin
        cyc_cnt <= 4'h0;
      end else if (step) begin
        cyc_cnt <= cyc_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= keyscan_pkg::CONFIG_RESET[6:0];
      debounce <= keyscan_pkg::DEBOUNCE_RESET;
      irq_cfg <= keyscan_pkg::IRQ_RESET;
      repeat_cfg <= keyscan_pkg::REPEAT_RESET;
      sleep_cfg <= keyscan_pkg::SLEEP_RESET;
      dims <= keyscan_pkg::DIM_RESET;
    end else if (access.wr) begin
      unique case (access.addr)
        keyscan_pkg::REG_SCAN_CONFIG: cfg <= access.data[6:0];
        keyscan_pkg::REG_DEBOUNCE: debounce <= access.data;
        keyscan_pkg::REG_IRQ_TRIGGER: irq_cfg <= access.data;
        keyscan_pkg::REG_REPEAT: repeat_cfg <= access.data;
        keyscan_pkg::REG_IDLE_SLEEP: sleep_cfg <= access.data;
        keyscan_pkg::REG_MATRIX_DIM: dims <= access.data;
        default: begin
        end
      endcase
    end
  end

  // Each key keeps its own step count, so keys debounce independently.
  for (genvar i = 0; i < 64; i++) begin : key
    logic [3:0] cnt;
    logic state;
    assign span_mask[i] = in_span(i, dims); // RULE17
    assign deb[i] = state;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt <= 4'h0;
        state <= 1'b0;
      end else if (!span_mask[i]) begin
        cnt <= 4'h0; // RULE26
        state <= 1'b0;
      end else if (!running || sw_sync[i] == state) begin
        cnt <= 4'h0;
      end else if (step) begin
        if (cnt == (state ? debounce[7:4] : debounce[3:0])) begin
          state <= sw_sync[i]; // RULE7
          cnt <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end

  // Lowest changed index is reported first; others wait a cycle.
  always_comb begin
    pick_valid = 1'b0;
    pick_idx = 6'h00;
    for (int i = 63; i >= 0; i--) begin
      if (span_mask[i] && deb[i] != rep[i]) begin
        pick_valid = 1'b1;
        pick_idx = 6'(i);
      end
    end
  end

  assign ev_press = deb[pick_idx];
  assign key_push = pick_valid && (ev_press || rel_en);
  assign push = key_push || rpt_fire;
  assign push_byte = key_push ? {ev_press, pick_idx} // RULE2 RULE4
                              : keyscan_pkg::REPEAT_CODE; // RULE11
  assign push_ok = push && (!full || pop);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rep <= 64'h0;
    end else begin
      rep <= rep & span_mask;
      if (pick_valid) begin
        rep[pick_idx] <= deb[pick_idx];
      end
    end
  end

  assign next_delay = 8'((9'(repeat_cfg[3:0]) + 9'h001)
                         * 9'(keyscan_pkg::REPEAT_DELAY_UNIT)); // RULE12
  assign next_rate = 8'((9'(repeat_cfg[6:4]) + 9'h001)
                        * 9'(keyscan_pkg::REPEAT_RATE_UNIT)); // RULE13
  assign rpt_fire = cycle && running && !pick_valid && |deb
                    && repeat_cfg[keyscan_pkg::REPEAT_EN_BIT]
                    && rpt_cnt <= 8'h01;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rpt_cnt <= 8'h00;
    end else if (pick_valid) begin
      rpt_cnt <= next_delay; // RULE14 RULE15
    end else if (rpt_fire) begin
      rpt_cnt <= next_rate; // RULE14
    end else if (cycle && running && |deb) begin
      rpt_cnt <= rpt_cnt - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (push_ok) begin
      fifo_mem[wr_ptr] <= push_byte;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count <= 5'h00;
      ovf <= 1'b0;
      extra_full <= 1'b0;
    end else if (host_wake && !running) begin
      wr_ptr <= 4'h0; // RULE24
      rd_ptr <= 4'h0;
      count <= 5'h00;
      ovf <= 1'b0;
      extra_full <= 1'b0;
    end else begin
      if (pop) begin
        rd_ptr <= rd_ptr + 4'h1;
        extra_full <= 1'b0;
      end
      if (push_ok) begin
        wr_ptr <= wr_ptr + 4'h1;
      end
      count <= count + 5'(push_ok) - 5'(pop); // RULE21
      if (push && full && !pop) begin
        extra_full <= 1'b1;
        ovf <= !(extra_full && key_push && !ev_press); // RULE22
      end else if (!rel_en && push_ok && !pop && count == 5'h0F) begin
        ovf <= 1'b1; // RULE22
      end else if (queue_read) begin
        ovf <= 1'b0; // RULE21
      end
    end
  end

  always_comb begin
    unique case (access.addr)
      keyscan_pkg::REG_EVENT_QUEUE: begin
        if (ovf) begin
          read_data = keyscan_pkg::OVERFLOW_BYTE; // RULE21
        end else if (count == 5'h00) begin
          read_data = keyscan_pkg::EMPTY_BYTE; // RULE23
        end else begin
          read_data = {count > 5'h01, fifo_mem[rd_ptr]}; // RULE3 RULE23
        end
      end
      keyscan_pkg::REG_SCAN_CONFIG: read_data = {running, cfg}; // RULE18
      keyscan_pkg::REG_DEBOUNCE: read_data = debounce;
      keyscan_pkg::REG_IRQ_TRIGGER: read_data = irq_cfg;
      keyscan_pkg::REG_REPEAT: read_data = repeat_cfg;
      keyscan_pkg::REG_IDLE_SLEEP: read_data = sleep_cfg;
      keyscan_pkg::REG_MATRIX_DIM: read_data = dims;
      default: read_data = 8'h00;
    endcase
  end

  // The time trigger starts at the first queued event and counts cycles.
  assign t_fire = t_armed && cycle && tcnt + 5'h01 == irq_cfg[4:0];
  assign lvl_hit = irq_cfg[7:5] != 3'h0
                   && count >= 5'(irq_cfg[7:5] * 3'(keyscan_pkg::LEVEL_UNIT));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tcnt <= 5'h00;
      t_armed <= 1'b0;
    end else if (t_fire || irq_cfg[4:0] == 5'h00) begin
      t_armed <= 1'b0;
    end else if (push_ok && !t_armed) begin
      t_armed <= 1'b1; // RULE9
      tcnt <= 5'h00;
    end else if (t_armed && cycle) begin
      tcnt <= tcnt + 5'h01;
    end
  end

  // A new trigger in the same cycle as a clearing read keeps the line set.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (irq_cfg == 8'h00) begin
      irq <= 1'b0; // RULE8
    end else if (t_fire || lvl_hit) begin
      irq <= 1'b1; // RULE9 RULE10
    end else if (cfg[keyscan_pkg::CFG_EMPTY_CLEAR_BIT]
                 ? (count == 5'h00 && !ovf) : queue_read) begin
      irq <= 1'b0; // RULE5
    end
  end

  assign idle_limit = 10'(sleep_cfg[2:0]
                          * 10'(keyscan_pkg::SLEEP_UNIT_STEPS));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt <= 10'h000;
    end else if (!running || |deb || |(sw_sync & span_mask)) begin
      idle_cnt <= 10'h000;
    end else if (step && idle_cnt != 10'h3FF) begin
      idle_cnt <= idle_cnt + 10'h001;
    end
  end

  // Sleep holds every key's debounce state, so the queue survives it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pstate <= keyscan_pkg::PWR_SLEEP; // RULE25
      warm_cnt <= 2'h0;
    end else if (access.wr
                 && access.addr == keyscan_pkg::REG_SCAN_CONFIG) begin
      pstate <= access.data[keyscan_pkg::CFG_RUN_BIT]
                ? keyscan_pkg::PWR_RUN : keyscan_pkg::PWR_SLEEP; // RULE6
    end else begin
      unique case (pstate)
        keyscan_pkg::PWR_SLEEP: begin
          if (cfg[keyscan_pkg::CFG_AUTOWAKE_BIT]
              && |(sw_sync & span_mask)) begin
            pstate <= keyscan_pkg::PWR_WARMUP; // RULE18 RULE20
            warm_cnt <= 2'h0;
          end
        end
        keyscan_pkg::PWR_WARMUP: begin
          if (step) begin
            if (warm_cnt == 2'(keyscan_pkg::WARMUP_STEPS - 1)) begin
              pstate <= keyscan_pkg::PWR_RUN; // RULE19
            end else begin
              warm_cnt <= warm_cnt + 2'h1;
            end
          end
        end
        keyscan_pkg::PWR_RUN: begin
          if (idle_limit != 10'h000 && idle_cnt > idle_limit) begin
            pstate <= keyscan_pkg::PWR_SLEEP; // RULE16
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_irq_n <= 1'b1;
      scan_power_on <= 1'b0;
    end else begin
      key_irq_n <= ~irq;
      scan_power_on <= pstate != keyscan_pkg::PWR_SLEEP;
    end
  end

endmodule

/* keyscan_event_fifo_controller_assertions.sv */
`timescale 1ns/100ps
module keyscan_checker (
  // Watched pins
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic key_irq_n,
  input wire logic scan_power_on
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence reset_gone;
    $rose(rst_n);
  endsequence
  sequence scl_fall;
    $fell(scl_in);
  endsequence
  sequence power_up;
    $rose(scan_power_on);
  endsequence
  chk_reset_quiet: assert property (
    reset_gone |-> !scan_power_on && key_irq_n && !sda_oe)
    else $error("outputs active after reset");
  chk_irq_off_start: assert property (
    reset_gone |-> key_irq_n [*8])
    else $error("interrupt with cleared trigger setting");
  chk_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  chk_drive_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data pulled while clock high");
  chk_steady_scl_high: assert property (
    scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data moved while clock high");
  // The pin passes two flops, so no answer can come sooner.
  chk_sync_delay: assert property (scl_fall |-> $stable(sda_oe) [*2])
    else $error("data answered too early");
  chk_warmup_hold: assert property (
    power_up |-> scan_power_on [*8])
    else $error("scan supply dropped after wake");
  chk_sleep_hold: assert property (
    $fell(scan_power_on) |=> !scan_power_on [*2])
    else $error("sleep left at once");
endmodule
bind keyscan_event_fifo_controller keyscan_checker u_chk (
  .clk(clk),
  .rst_n(rst_n),
  .scl_in(scl_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .key_irq_n(key_irq_n),
  .scan_power_on(scan_power_on)
);

/* keyscan_host_model.sv */
`timescale 1ns/100ps
module keyscan_host_model (
  // Clock
  input wire logic clk,
  // Bus lines
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull,
  // Read results
  output logic rd_valid,
  output logic [7:0] rd_data,
  output int nacks
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
    nacks = 0;
  end
  // Six cycles a quarter keeps each clock phase above four cycles.
  task automatic qtr();
    repeat (6) @(negedge clk);
  endtask
  task automatic start();
    sda_pull = 1'b0;
    qtr();
    scl = 1'b1;
    qtr();
    sda_pull = 1'b1;
    qtr();
    scl = 1'b0;
    qtr();
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    qtr();
    scl = 1'b1;
    qtr();
    sda_pull = 1'b0;
    qtr();
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_pull = !b;
    qtr();
    scl = 1'b1;
    qtr();
    s = sda_line;
    qtr();
    scl = 1'b0;
    qtr();
  endtask
  task automatic put(input logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], s);
    end
    bit_io(1'b1, s);
    nacks += int'(s);
  endtask
  task automatic get(input logic last);
    logic s;
    logic [7:0] v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      v[i] = s;
    end
    rd_data = v;
    rd_valid = 1'b1;
    @(negedge clk);
    rd_valid = 1'b0;
    bit_io(last, s);
  endtask
endmodule

/* keyscan_event_fifo_controller_tb.sv */
`timescale 1ns/100ps
module keyscan_event_fifo_controller_tb;
  localparam int STEP = 768;
  localparam logic [15:0] RST_TBL [8] = '{16'h010B, 16'h02FF, 16'h0300,
    16'h0500, 16'h0607, 16'h30FF, 16'h003F, 16'h0400};
  logic clk = 1'b0;
  logic osc_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [63:0] switch_closed = '0;
  logic scl, sda_pull, sda_out, sda_oe, key_irq_n, scan_power_on;
  logic rd_valid;
  logic [7:0] rd_data;
  int nacks;
  int err_count = 0;
  int comparisons = 0;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h12D4DFFA;
  logic [5:0] base;
  wire logic sda_line = !(sda_oe || sda_pull);
  always #5 clk = !clk;
  initial #3 forever #15 osc_clk = !osc_clk;
  keyscan_event_fifo_controller dut (.clk(clk), .rst_n(rst_n),
    .osc_clk(osc_clk), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .switch_closed(switch_closed),
    .key_irq_n(key_irq_n), .scan_power_on(scan_power_on));
  keyscan_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl),
    .sda_pull(sda_pull), .rd_valid(rd_valid), .rd_data(rd_data),
    .nacks(nacks));
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Indices 62 and 63 are avoided so bits 7 and 6 always mean something.
  function automatic logic [5:0] key(input int i);
    return 6'((int'(base) + i * 7) % 62);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.start();
    host.put(8'h70);
    host.put(a);
    host.put(d);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    host.start();
    host.put(8'h70);
    host.put(a);
    host.start();
    host.put(8'h71);
    for (int i = 0; i < n; i++) begin
      host.get(i == n - 1);
    end
    host.stop();
  endtask
  task automatic steps(input int n);
    repeat (n * STEP + 200) @(negedge clk);
  endtask
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      check(rd_data, exp_q.pop_front());
    end
  end
  initial begin
    repeat (95000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    seed = xorshift(seed);
    base = seed[5:0];
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check({7'h00, scan_power_on}, 8'h00);
    foreach (RST_TBL[i]) begin
      exp_q.push_back(RST_TBL[i][7:0]);
      rd(RST_TBL[i][15:8], 1);
    end
    // Run, clear on any queue read, releases reported, autowake on.
    wr(8'h01, 8'h8A);
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h01);
    exp_q.push_back(8'h8A);
    rd(8'h01, 1);
    check({7'h00, scan_power_on}, 8'h01);
    switch_closed[key(0)] = 1'b1;
    steps(4);
    check({7'h00, key_irq_n}, 8'h00);
    exp_q.push_back({2'b01, key(0)});
    rd(8'h00, 1);
    check({7'h00, key_irq_n}, 8'h01);
    switch_closed[key(0)] = 1'b0;
    steps(2);
    exp_q.push_back({2'b00, key(0)});
    rd(8'h00, 1);
    for (int i = 1; i <= 9; i++) begin
      switch_closed[key(i)] = 1'b1;
      steps(2);
      if (i < 9) begin
        switch_closed[key(i)] = 1'b0;
        steps(2);
      end
    end
    exp_q.push_back(8'h7F);
    for (int i = 1; i <= 8; i++) begin
      exp_q.push_back({2'b11, key(i)});
      exp_q.push_back({1'(i < 8), 1'b0, key(i)});
    end
    rd(8'h00, 17);
    switch_closed[key(9)] = 1'b0;
    steps(2);
    wr(8'h01, 8'h0A);
    repeat (20) @(negedge clk);
    check({7'h00, scan_power_on}, 8'h00);
    switch_closed[key(10)] = 1'b1;
    steps(4);
    check({7'h00, scan_power_on}, 8'h01);
    exp_q.push_back(8'h8A);
    rd(8'h01, 1);
    exp_q.push_back({2'b10, key(9)});
    exp_q.push_back({2'b01, key(10)});
    rd(8'h00, 2);
    wr(8'h30, 8'h00);
    seed = xorshift(seed);
    switch_closed = {seed, ~seed};
    steps(2);
    exp_q.push_back(8'h3F);
    rd(8'h00, 1);
    switch_closed = '0;
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    exp_q.push_back(8'h0B);
    rd(8'h01, 1);
    check(8'(nacks), 8'h00);
    report_and_stop();
  end
endmodule
